// File: hw/ext_bus_params.svh
// Constants of the external area bus interface
`ifndef EXT_BUS_PARAMS_SVH
`define EXT_BUS_PARAMS_SVH
`define EB_ADDR_W 24
`define EB_AREA_MSB 23
`define EB_AREA_LSB 21
`define EB_AREA0 3'h0
`define EB_AREA7 3'h7
`define EB_MODSEL_FIRST 24'hFFFF40
`define EB_MODSEL_LAST 24'hFFFF5F
`define EB_ROM_LAST 24'h01FFFF
`define EB_RAM_FIRST 24'hFFB000
`define EB_RAM_LAST 24'hFFEFFF
`define EB_IO_FIRST 24'hFFFF60
`define EB_IO_LAST 24'hFFFFFF
`define EB_CS_DIR_ROMLESS 8'h01
`define EB_CS_DIR_ROM 8'h00
`define EB_SYNC_STAGES 2
`define EB_SETTLE_CYCLES 3
`endif

// File: hw/ext_bus_pkg.sv
// Types of the external area bus interface
package ext_bus_pkg;
	typedef enum logic [1:0] {
		SZ_BYTE = 2'h0,
		SZ_WORD = 2'h1,
		SZ_LONG = 2'h2
	} size_t;
	typedef struct packed {
		logic [23:0] addr;
		logic write;
		size_t size;
		logic [31:0] wdata;
	} bus_req_t;
	typedef struct packed {
		logic external;
		logic module_sel;
		logic [2:0] area;
	} decode_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_T1 = 3'h1,
		ST_T2 = 3'h2,
		ST_TW = 3'h3,
		ST_T3 = 3'h4,
		ST_SETTLE = 3'h5,
		ST_DONE = 3'h6
	} bus_state_t;
endpackage

// File: hw/pin_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
	parameter int W = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta <= '0;
			q_o <= '0;
		end else begin
			meta <= d_i;
			q_o <= meta;
		end
	end
endmodule // pin_sync
`default_nettype wire

// File: hw/area_decoder.sv
// Address to area and external space decoder
`timescale 1ns/10ps
`default_nettype none
`include "ext_bus_params.svh"
module area_decoder #(
	parameter logic [23:0] ROM_LAST = `EB_ROM_LAST,
	parameter logic [23:0] RAM_FIRST = `EB_RAM_FIRST,
	parameter logic [23:0] RAM_LAST = `EB_RAM_LAST
) (
	input wire logic [23:0] addr_i,
	input wire logic rom_enable_i,
	input wire logic ram_enable_i,
	input wire logic modsel_enable_i,
	output ext_bus_pkg::decode_t dec_o
);
	logic in_rom;
	logic in_ram;
	logic in_io;
	logic in_mod;
	always_comb begin
		dec_o.area = addr_i[`EB_AREA_MSB:`EB_AREA_LSB];
		in_rom = rom_enable_i && (addr_i <= ROM_LAST);
		in_ram = ram_enable_i && (addr_i >= RAM_FIRST) && (addr_i <= RAM_LAST);
		in_io = (addr_i >= `EB_IO_FIRST);
		in_mod = modsel_enable_i && (addr_i >= `EB_MODSEL_FIRST)
			&& (addr_i <= `EB_MODSEL_LAST);
		dec_o.module_sel = in_mod;
		dec_o.external = !(in_rom || in_ram || in_io);
	end
endmodule // area_decoder
`default_nettype wire

// File: hw/ext_bus_ctrl.sv
// Basic external bus interface with eight chip-selected areas
`timescale 1ns/10ps
`default_nettype none
`include "ext_bus_params.svh"
// Contract
// - Three-state areas get zero to three program waits chosen per area.
// - Width bit set means 8-bit; state bit picks 2 or 3 states.
// - Areas start as basic interface, three-state, width from mode.
// - Only area 0 may be switched to burst ROM interface.
// - Areas 1 to 7 always use the basic interface.
// - Area 0 fully external without ROM, else outside ROM only.
// - On-chip RAM range internal only while RAM enable is set.
// - Module select drives for FFFF40-FFFF5F when its enable is set.
// - Area chip select goes low while its external space is accessed; the code keeps area 7 high for FFFF40-FFFF5F while module select is enabled.
// - Chip select pin enabled by its port direction bit.
// - Without ROM, select 0 is output after reset, others inputs.
// - With ROM, all eight selects are inputs after reset.
// - Eight-bit areas carry all data on the upper half.
// - Eight-bit areas split words in two and longwords in four.
// - Sixteen-bit areas move byte or word, longword as two words.
// - Sixteen-bit byte access: even on upper, odd on lower half.
// - Reads use one read strobe for either half.
// - Upper and lower write strobes follow the halves written.
// - Unused half floats on writes and is ignored on reads.
// - Program waits sit between the second and third state.
// - Two-state areas never get wait states.
// - Bus mode is 8-bit only when all areas are 8-bit.
module ext_bus_ctrl #(
	parameter logic [23:0] ROM_LAST = `EB_ROM_LAST,
	parameter logic [23:0] RAM_FIRST = `EB_RAM_FIRST,
	parameter logic [23:0] RAM_LAST = `EB_RAM_LAST,
	parameter int SETTLE_CYCLES = `EB_SETTLE_CYCLES
) (
	input wire logic MCLK_I,
	input wire logic RST_I,
	input wire logic REQ_VALID_I,
	input wire ext_bus_pkg::bus_req_t REQ_I,
	output logic REQ_READY_O,
	output logic RSP_VALID_O,
	output logic RSP_INTERNAL_O,
	output logic [31:0] RSP_RDATA_O,
	input wire logic ROM_ENABLE_I,
	input wire logic ONCHIP_RAM_ENABLE_I,
	input wire logic MODULE_SELECT_OUTPUT_ENABLE_I,
	input wire logic BURST_ROM_SELECT_I,
	input wire logic [7:0] AREA_WIDTH_CONTROL_I,
	input wire logic [7:0] AREA_STATE_CONTROL_I,
	input wire logic [7:0] WAIT_COUNT_CONTROL_HIGH_I,
	input wire logic [7:0] WAIT_COUNT_CONTROL_LOW_I,
	input wire logic CS_DIR_WE_I,
	input wire logic [7:0] CS_DIR_I,
	output logic [7:0] CS_DIR_O,
	output logic [7:0] AREA_CHIP_SELECT_N_O,
	output logic [7:0] AREA_CHIP_SELECT_OE_O,
	output logic MODULE_SELECT_N_O,
	output logic [23:0] ADDR_O,
	output logic RD_N_O,
	output logic UPPER_WRITE_STROBE_N_O,
	output logic LOWER_WRITE_STROBE_N_O,
	input wire logic [15:0] DATA_I,
	output logic [15:0] DATA_O,
	output logic [1:0] DATA_OE_O,
	output logic BUS_MODE_16_O
);
	// Settle must cover the output flop and both synchroniser stages
	if (SETTLE_CYCLES < `EB_SYNC_STAGES + 1 || SETTLE_CYCLES > 3) begin : g_bad_settle
		$error("SETTLE_CYCLES must be three");
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [1:0] access_last(input logic w8, input ext_bus_pkg::size_t sz);
		access_last = 2'h0;
		if (sz == ext_bus_pkg::SZ_WORD && w8)
			access_last = 2'h1;
		else if (sz == ext_bus_pkg::SZ_LONG)
			access_last = w8 ? 2'h3 : 2'h1;
	endfunction

	function automatic logic [23:0] access_addr(input logic [23:0] a, input logic w8,
		input ext_bus_pkg::size_t sz, input logic [1:0] k);
		logic [23:0] b;
		b = (sz == ext_bus_pkg::SZ_BYTE) ? a : {a[23:1], 1'b0};
		if (w8)
			access_addr = b + {22'h0, k};
		else
			access_addr = b + {21'h0, k, 1'b0};
	endfunction

	function automatic logic [1:0] lanes(input logic w8, input ext_bus_pkg::size_t sz,
		input logic a0);
		if (w8)
			lanes = 2'h2;
		else if (sz == ext_bus_pkg::SZ_BYTE)
			lanes = a0 ? 2'h1 : 2'h2;
		else
			lanes = 2'h3;
	endfunction

	function automatic logic [15:0] lane_wdata(input logic w8, input ext_bus_pkg::size_t sz,
		input logic a0, input logic [1:0] j, input logic [31:0] wd);
		lane_wdata = 16'h0000;
		if (w8)
			lane_wdata = {wd[8*j +: 8], 8'h00};
		else if (sz == ext_bus_pkg::SZ_BYTE)
			lane_wdata = a0 ? {8'h00, wd[7:0]} : {wd[7:0], 8'h00};
		else
			lane_wdata = wd[16*j[0] +: 16];
	endfunction

	// ----------------------------------------
	// Decode and per-area configuration
	// ----------------------------------------
	ext_bus_pkg::decode_t dec;
	logic [15:0] data_sync;
	logic take;
	logic req_w8;
	ext_bus_pkg::bus_state_t state;
	ext_bus_pkg::bus_state_t next_state;
	ext_bus_pkg::bus_req_t req;
	ext_bus_pkg::decode_t cur;
	logic w8;
	logic three_st;
	logic [1:0] waits;
	logic [1:0] wait_cnt;
	logic [1:0] acc_idx;
	logic [1:0] acc_last;
	logic [1:0] settle_cnt;
	logic [31:0] rdata;
	logic [23:0] cur_addr;
	logic [1:0] cur_lanes;
	logic more;
	logic in_bus;
	logic in_strobe;

	area_decoder #(
		.ROM_LAST(ROM_LAST),
		.RAM_FIRST(RAM_FIRST),
		.RAM_LAST(RAM_LAST)
	) u_dec (
		.addr_i(REQ_I.addr),
		.rom_enable_i(ROM_ENABLE_I),
		.ram_enable_i(ONCHIP_RAM_ENABLE_I),
		.modsel_enable_i(MODULE_SELECT_OUTPUT_ENABLE_I),
		.dec_o(dec)
	);

	pin_sync #(
		.W(16)
	) u_sync (
		.clk_i(MCLK_I),
		.rst_i(RST_I),
		.d_i(DATA_I),
		.q_o(data_sync)
	);

	assign take = REQ_VALID_I && REQ_READY_O;
	// Burst ROM forces area 0 to 16-bit; no other area has that option
	assign req_w8 = AREA_WIDTH_CONTROL_I[dec.area]
		&& !(dec.area == `EB_AREA0 && BURST_ROM_SELECT_I);
	assign cur_addr = access_addr(req.addr, w8, req.size, acc_idx);
	assign cur_lanes = lanes(w8, req.size, cur_addr[0]);
	assign more = acc_idx != acc_last;
	assign in_bus = state inside {ext_bus_pkg::ST_T1, ext_bus_pkg::ST_T2,
		ext_bus_pkg::ST_TW, ext_bus_pkg::ST_T3, ext_bus_pkg::ST_SETTLE};
	assign in_strobe = state inside {ext_bus_pkg::ST_T2, ext_bus_pkg::ST_TW};

	// ----------------------------------------
	// Bus cycle sequencer
	// ----------------------------------------
	function automatic ext_bus_pkg::bus_state_t after_bus(input logic wr, input logic m);
		if (!wr)
			after_bus = ext_bus_pkg::ST_SETTLE;
		else
			after_bus = m ? ext_bus_pkg::ST_T1 : ext_bus_pkg::ST_DONE;
	endfunction

	always_comb begin
		next_state = state;
		case (state)
			ext_bus_pkg::ST_IDLE: begin
				if (take)
					next_state = dec.external ? ext_bus_pkg::ST_T1 : ext_bus_pkg::ST_DONE;
			end
			ext_bus_pkg::ST_T1: begin
				next_state = ext_bus_pkg::ST_T2;
			end
			ext_bus_pkg::ST_T2: begin
				if (!three_st)
					next_state = after_bus(req.write, more);
				else if (waits != 2'h0)
					next_state = ext_bus_pkg::ST_TW;
				else
					next_state = ext_bus_pkg::ST_T3;
			end
			ext_bus_pkg::ST_TW: begin
				if (wait_cnt == 2'h1)
					next_state = ext_bus_pkg::ST_T3;
			end
			ext_bus_pkg::ST_T3: begin
				next_state = after_bus(req.write, more);
			end
			ext_bus_pkg::ST_SETTLE: begin
				if (settle_cnt == 2'(SETTLE_CYCLES - 1))
					next_state = more ? ext_bus_pkg::ST_T1 : ext_bus_pkg::ST_DONE;
			end
			ext_bus_pkg::ST_DONE: begin
				next_state = ext_bus_pkg::ST_IDLE;
			end
			default: begin
				next_state = ext_bus_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge MCLK_I) begin
		if (RST_I)
			state <= ext_bus_pkg::ST_IDLE;
		else
			state <= next_state;
	end

	// Latch the request and its area settings
	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			req <= '0;
			cur <= '0;
			w8 <= 1'b0;
			three_st <= 1'b1;
			waits <= 2'h0;
			acc_last <= 2'h0;
		end else if (take) begin
			req <= REQ_I;
			cur <= dec;
			w8 <= req_w8;
			three_st <= AREA_STATE_CONTROL_I[dec.area];
			waits <= dec.area[2] ? WAIT_COUNT_CONTROL_HIGH_I[2*dec.area[1:0] +: 2]
				: WAIT_COUNT_CONTROL_LOW_I[2*dec.area[1:0] +: 2];
			acc_last <= access_last(req_w8, REQ_I.size);
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (RST_I)
			acc_idx <= 2'h0;
		else if (take)
			acc_idx <= 2'h0;
		else if (next_state == ext_bus_pkg::ST_T1 && state != ext_bus_pkg::ST_IDLE)
			acc_idx <= acc_idx + 2'h1;
	end

	always_ff @(posedge MCLK_I) begin
		if (RST_I)
			wait_cnt <= 2'h0;
		else if (state == ext_bus_pkg::ST_T2)
			wait_cnt <= waits;
		else if (state == ext_bus_pkg::ST_TW)
			wait_cnt <= wait_cnt - 2'h1;
	end

	always_ff @(posedge MCLK_I) begin
		if (RST_I)
			settle_cnt <= 2'h0;
		else if (state == ext_bus_pkg::ST_SETTLE)
			settle_cnt <= settle_cnt + 2'h1;
		else
			settle_cnt <= 2'h0;
	end

	// Read data gathered most significant part first
	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			rdata <= 32'h00000000;
		end else if (take) begin
			rdata <= 32'h00000000;
		end else if (state == ext_bus_pkg::ST_SETTLE
			&& settle_cnt == 2'(SETTLE_CYCLES - 1)) begin
			if (cur_lanes == 2'h3)
				rdata <= {rdata[15:0], data_sync};
			else if (cur_lanes == 2'h2)
				rdata <= {rdata[23:0], data_sync[15:8]};
			else
				rdata <= {rdata[23:0], data_sync[7:0]};
		end
	end

	// ----------------------------------------
	// Request and response ports
	// ----------------------------------------
	always_ff @(posedge MCLK_I) begin
		if (RST_I)
			REQ_READY_O <= 1'b0;
		else
			REQ_READY_O <= (next_state == ext_bus_pkg::ST_IDLE) && !take;
	end

	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			RSP_VALID_O <= 1'b0;
			RSP_INTERNAL_O <= 1'b0;
			RSP_RDATA_O <= 32'h00000000;
		end else begin
			RSP_VALID_O <= state == ext_bus_pkg::ST_DONE;
			if (state == ext_bus_pkg::ST_DONE) begin
				RSP_INTERNAL_O <= !cur.external;
				RSP_RDATA_O <= (cur.external && !req.write) ? rdata : 32'h00000000;
			end
		end
	end

	// ----------------------------------------
	// Chip select direction and bus mode
	// ----------------------------------------
	always_ff @(posedge MCLK_I) begin
		if (RST_I)
			CS_DIR_O <= ROM_ENABLE_I ? `EB_CS_DIR_ROM : `EB_CS_DIR_ROMLESS;
		else if (CS_DIR_WE_I)
			CS_DIR_O <= CS_DIR_I;
	end

	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			AREA_CHIP_SELECT_OE_O <= 8'h00;
			BUS_MODE_16_O <= 1'b0;
		end else begin
			AREA_CHIP_SELECT_OE_O <= CS_DIR_O;
			BUS_MODE_16_O <= !(&AREA_WIDTH_CONTROL_I) || BURST_ROM_SELECT_I;
		end
	end

	// ----------------------------------------
	// Pin drivers, one cycle behind the sequencer
	// ----------------------------------------
	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			AREA_CHIP_SELECT_N_O <= 8'hFF;
			MODULE_SELECT_N_O <= 1'b1;
			ADDR_O <= 24'h000000;
		end else begin
			AREA_CHIP_SELECT_N_O <= 8'hFF;
			if (in_bus && !cur.module_sel)
				AREA_CHIP_SELECT_N_O[cur.area] <= 1'b0;
			MODULE_SELECT_N_O <= !(in_bus && cur.module_sel);
			if (in_bus)
				ADDR_O <= cur_addr;
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			RD_N_O <= 1'b1;
			UPPER_WRITE_STROBE_N_O <= 1'b1;
			LOWER_WRITE_STROBE_N_O <= 1'b1;
		end else begin
			RD_N_O <= !(in_bus && !req.write);
			UPPER_WRITE_STROBE_N_O <= !(in_strobe && req.write && cur_lanes[1]);
			LOWER_WRITE_STROBE_N_O <= !(in_strobe && req.write && cur_lanes[0]);
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (RST_I) begin
			DATA_O <= 16'h0000;
			DATA_OE_O <= 2'h0;
		end else begin
			DATA_O <= lane_wdata(w8, req.size, cur_addr[0], acc_last - acc_idx,
				req.wdata);
			if (req.write && in_bus && state != ext_bus_pkg::ST_SETTLE)
				DATA_OE_O <= cur_lanes;
			else
				DATA_OE_O <= 2'h0;
		end
	end
endmodule // ext_bus_ctrl
`default_nettype wire

// File: verif/ext_bus_chk.sv
// Pin-level checks of the external area bus interface
`timescale 1ns/10ps
`default_nettype none
module ext_bus_chk (
	input wire logic MCLK_I,
	input wire logic RST_I,
	input wire logic REQ_VALID_I,
	input wire logic REQ_READY_O,
	input wire logic RSP_VALID_O,
	input wire logic RSP_INTERNAL_O,
	input wire logic [7:0] CS_DIR_O,
	input wire logic [7:0] AREA_CHIP_SELECT_N_O,
	input wire logic [7:0] AREA_CHIP_SELECT_OE_O,
	input wire logic MODULE_SELECT_N_O,
	input wire logic RD_N_O,
	input wire logic UPPER_WRITE_STROBE_N_O,
	input wire logic LOWER_WRITE_STROBE_N_O,
	input wire logic [1:0] DATA_OE_O
);
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (RST_I);
	sequence s_take;
		REQ_VALID_I && REQ_READY_O;
	endsequence
	sequence s_quiet;
		&AREA_CHIP_SELECT_N_O && RD_N_O && UPPER_WRITE_STROBE_N_O && LOWER_WRITE_STROBE_N_O;
	endsequence
	a_take_answer: assert property (s_take |-> ##[2:80] RSP_VALID_O)
		else $error("no response after a request");
	a_read_quiet: assert property (!RD_N_O |-> DATA_OE_O == 2'h0
		&& UPPER_WRITE_STROBE_N_O && LOWER_WRITE_STROBE_N_O)
		else $error("data driven or written during a read");
	a_upper_half: assert property (!UPPER_WRITE_STROBE_N_O |-> DATA_OE_O[1])
		else $error("upper strobe without upper data");
	a_lower_half: assert property (!LOWER_WRITE_STROBE_N_O |-> DATA_OE_O[0])
		else $error("lower strobe without lower data");
	a_one_select: assert property ($onehot0(~AREA_CHIP_SELECT_N_O))
		else $error("two selects low");
	a_modsel_alone: assert property (!MODULE_SELECT_N_O |-> &AREA_CHIP_SELECT_N_O)
		else $error("area select with module select");
	a_strobe_selected: assert property ((!UPPER_WRITE_STROBE_N_O || !LOWER_WRITE_STROBE_N_O)
		|-> !(&AREA_CHIP_SELECT_N_O) || !MODULE_SELECT_N_O)
		else $error("write strobe with no select");
	a_oe_follows: assert property (!$past(RST_I) |-> AREA_CHIP_SELECT_OE_O == $past(CS_DIR_O))
		else $error("select enable not following direction");
	a_internal_quiet: assert property (RSP_VALID_O && RSP_INTERNAL_O
		|-> s_quiet and $past(&AREA_CHIP_SELECT_N_O))
		else $error("pins moved on an internal access");
endmodule // ext_bus_chk
bind ext_bus_ctrl ext_bus_chk chk (.*);
`default_nettype wire

// File: verif/ext_mem_model.sv
// Byte memory standing on the external data bus
`timescale 1ns/10ps
`default_nettype none
module ext_mem_model (
	input wire logic clk_i,
	input wire logic [23:0] addr_i,
	input wire logic [7:0] cs_n_i,
	input wire logic ms_n_i,
	input wire logic rd_n_i,
	input wire logic uws_n_i,
	input wire logic lws_n_i,
	input wire logic [15:0] dout_i,
	output logic [15:0] din_o
);
	logic [7:0] mem [256];
	logic [15:0] last = 16'hA5A5;
	logic [7:0] ev;
	logic [7:0] od;
	logic rd;
	assign ev = addr_i[7:0];
	assign od = {addr_i[7:1], 1'b1};
	assign rd = (~&cs_n_i || !ms_n_i) && !rd_n_i;
	// Released bus shows the inverse of the last value
	assign din_o = rd ? {mem[ev], mem[od]} : ~last;
	always_ff @(posedge clk_i) begin
		if (!uws_n_i) mem[ev] <= dout_i[15:8];
		if (!lws_n_i) mem[od] <= dout_i[7:0];
		if (rd) last <= din_o;
	end
endmodule // ext_mem_model
`default_nettype wire

// File: verif/ext_bus_ctrl_tb.sv
// Self-checking bench of the external area bus interface
`timescale 1ns/10ps
`default_nettype none
module ext_bus_ctrl_tb;
	localparam ext_bus_pkg::size_t sb = ext_bus_pkg::SZ_BYTE;
	localparam ext_bus_pkg::size_t sw = ext_bus_pkg::SZ_WORD;
	localparam ext_bus_pkg::size_t sl = ext_bus_pkg::SZ_LONG;
	logic clk, rdy, rsv, rsi, msn, rdn, uwn, lwn, m16, ms_seen;
	logic rst = 1'b1, rv = 1'b0, rom = 1'b0, ram = 1'b1, mse = 1'b1, brs = 1'b0, dwe = 1'b0;
	logic [7:0] wid = 8'h04, stc = 8'h0C, wl = 8'h00, dir = 8'h00;
	logic [7:0] dq, area_chip_select_n, csoe, cs_seen;
	logic [1:0] doe, oe_seen, ws_seen;
	logic [15:0] din, dout;
	logic [23:0] adr;
	logic [31:0] rdat;
	logic [23:0] aq[$];
	int n_mismatch = 0, checks_done = 0, lat = 0;
	ext_bus_pkg::bus_req_t rq = '0;
	ext_bus_ctrl dut (.MCLK_I(clk), .RST_I(rst), .REQ_VALID_I(rv), .REQ_I(rq),
		.REQ_READY_O(rdy), .RSP_VALID_O(rsv), .RSP_INTERNAL_O(rsi), .RSP_RDATA_O(rdat),
		.ROM_ENABLE_I(rom), .ONCHIP_RAM_ENABLE_I(ram), .MODULE_SELECT_OUTPUT_ENABLE_I(mse),
		.BURST_ROM_SELECT_I(brs), .AREA_WIDTH_CONTROL_I(wid), .AREA_STATE_CONTROL_I(stc),
		.WAIT_COUNT_CONTROL_HIGH_I(8'h00), .WAIT_COUNT_CONTROL_LOW_I(wl), .CS_DIR_WE_I(dwe),
		.CS_DIR_I(dir), .CS_DIR_O(dq), .AREA_CHIP_SELECT_N_O(area_chip_select_n), .AREA_CHIP_SELECT_OE_O(csoe),
		.MODULE_SELECT_N_O(msn), .ADDR_O(adr), .RD_N_O(rdn), .UPPER_WRITE_STROBE_N_O(uwn),
		.LOWER_WRITE_STROBE_N_O(lwn), .DATA_I(din), .DATA_O(dout), .DATA_OE_O(doe),
		.BUS_MODE_16_O(m16));
	ext_mem_model mem (.clk_i(clk), .addr_i(adr), .cs_n_i(area_chip_select_n), .ms_n_i(msn), .rd_n_i(rdn),
		.uws_n_i(uwn), .lws_n_i(lwn), .dout_i(dout), .din_o(din));
	// ----------------
	// Tasks
	// ----------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic xfer(input logic [23:0] a, input logic w, input ext_bus_pkg::size_t s,
		input logic [31:0] wd);
		int k;
		rv <= 1'b1;
		rq <= {a, w, s, wd};
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (rdy !== 1'b1 && k < 50);
		if (rdy !== 1'b1) begin
			n_mismatch++;
			$display("[FAIL] ready expected 1 seen %b", rdy);
		end
		rv <= 1'b0;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (rsv !== 1'b1 && k < 200);
		if (rsv !== 1'b1) begin
			n_mismatch++;
			$display("[FAIL] response expected 1 seen %b", rsv);
		end
	endtask
	task automatic probe(input logic [23:0] a, input logic ei, input logic [7:0] ec,
		input logic em);
		xfer(a, 1'b1, sb, 32'h55);
		chk("internal", {31'h0, ei}, {31'h0, rsi});
		chk("selects", {24'h0, ec}, {24'h0, cs_seen});
		chk("module select", {31'h0, em}, {31'h0, ms_seen});
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Pin activity of the current transfer
	always @(posedge clk) begin
		if (rv && rdy) begin
			lat <= 0;
			cs_seen <= 8'h00;
			ms_seen <= 1'b0;
			oe_seen <= 2'h0;
			ws_seen <= 2'h0;
			aq.delete();
		end else begin
			lat <= lat + 1;
			cs_seen <= cs_seen | ~area_chip_select_n;
			ms_seen <= ms_seen | ~msn;
			oe_seen <= oe_seen | doe;
			ws_seen <= ws_seen | ~{uwn, lwn};
			if ((~&area_chip_select_n || !msn) && (aq.size() == 0 || aq[$] != adr)) aq.push_back(adr);
		end
	end
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		$display("[FAIL] watchdog expected done seen hang");
		tally_and_finish();
	end
	// ----------------
	// Tests
	// ----------------
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		chk("dir reset", 32'h01, {24'h0, dq});
		chk("oe reset", 32'h01, {24'h0, csoe});
		dwe <= 1'b1;
		dir <= 8'hFF;
		@(posedge clk);
		dwe <= 1'b0;
		repeat (2) @(posedge clk);
		chk("oe loaded", 32'hFF, {24'h0, csoe});
		$display("test direction done");
		for (int w = 0; w < 4; w++) begin
			wl <= 8'(w << 4);
			xfer(24'h400040 + 24'(w), 1'b1, sb, 32'hA0 + 32'(w));
			chk("write latency", 32'(4 + w), lat);
			chk("write halves", 32'h2, {30'h0, oe_seen});
			chk("write strobes", 32'h2, {30'h0, ws_seen});
			xfer(24'h400040 + 24'(w), 1'b0, sb, 32'h0);
			chk("read latency", 32'(7 + w), lat);
			chk("read byte", 32'hA0 + 32'(w), rdat);
		end
		$display("test waits done");
		xfer(24'h200001, 1'b1, sb, 32'h5A);
		chk("odd latency", 32'h3, lat);
		chk("odd halves", 32'h1, {30'h0, oe_seen});
		chk("odd strobes", 32'h1, {30'h0, ws_seen});
		xfer(24'h200000, 1'b1, sb, 32'hC3);
		chk("even strobes", 32'h2, {30'h0, ws_seen});
		xfer(24'h200000, 1'b0, sw, 32'h0);
		chk("word read", 32'hC35A, rdat);
		chk("word latency", 32'h6, lat);
		chk("word accesses", 32'h1, aq.size());
		chk("word select", 32'h2, {24'h0, cs_seen});
		$display("test sixteen done");
		xfer(24'h400020, 1'b1, sl, 32'h11223344);
		chk("byte accesses", 32'h4, aq.size());
		foreach (aq[i]) chk("byte order", 32'h400020 + i, {8'h0, aq[i]});
		xfer(24'h400020, 1'b0, sl, 32'h0);
		chk("long via bytes", 32'h11223344, rdat);
		xfer(24'h200010, 1'b1, sl, 32'hAABBCCDD);
		chk("word count", 32'h2, aq.size());
		foreach (aq[i]) chk("word order", 32'h200010 + 2 * i, {8'h0, aq[i]});
		xfer(24'h200012, 1'b0, sw, 32'h0);
		chk("low word", 32'hCCDD, rdat);
		chk("mode mixed", 32'h1, {31'h0, m16});
		$display("test split done");
		probe(24'hFFC000, 1'b1, 8'h00, 1'b0);
		probe(24'hFFFF60, 1'b1, 8'h00, 1'b0);
		probe(24'hFFFF40, 1'b0, 8'h00, 1'b1);
		probe(24'h000100, 1'b0, 8'h01, 1'b0);
		ram <= 1'b0;
		mse <= 1'b0;
		rom <= 1'b1;
		probe(24'hFFC000, 1'b0, 8'h80, 1'b0);
		probe(24'hFFFF5F, 1'b0, 8'h80, 1'b0);
		probe(24'h000100, 1'b1, 8'h00, 1'b0);
		probe(24'h030000, 1'b0, 8'h01, 1'b0);
		$display("test map done");
		wid <= 8'hFF;
		probe(24'h200000, 1'b0, 8'h02, 1'b0);
		chk("mode byte", 32'h0, {31'h0, m16});
		brs <= 1'b1;
		probe(24'h030001, 1'b0, 8'h01, 1'b0);
		chk("burst area lane", 32'h1, {30'h0, oe_seen});
		probe(24'h200001, 1'b0, 8'h02, 1'b0);
		chk("other area lane", 32'h2, {30'h0, oe_seen});
		chk("mode burst", 32'h1, {31'h0, m16});
		$display("test mode done");
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		chk("dir rom reset", 32'h00, {24'h0, dq});
		chk("oe rom reset", 32'h00, {24'h0, csoe});
		probe(24'h200001, 1'b0, 8'h02, 1'b0);
		$display("test reset done");
		tally_and_finish();
	end
endmodule // ext_bus_ctrl_tb
`default_nettype wire
